/* File: ladder_pkg.sv */
// Package: register map, fields and constants of the ladder power timing block
package ladder_pkg;

  localparam logic [1:0] ADDR_LADDER_POWER = 2'h0;
  localparam logic [1:0] ADDR_CONTRAST     = 2'h1;
  localparam logic [1:0] ADDR_WAVEFORM     = 2'h2;
  localparam logic [1:0] ADDR_STATUS       = 2'h3;

  localparam int A_POWER_MSB   = 7;
  localparam int A_POWER_LSB   = 6;
  localparam int B_POWER_MSB   = 5;
  localparam int B_POWER_LSB   = 4;
  localparam int IDLE_BIT      = 3;
  localparam int A_LENGTH_MSB  = 2;
  localparam int A_LENGTH_LSB  = 0;
  localparam int CONTRAST_MSB  = 2;
  localparam int CONTRAST_LSB  = 0;
  localparam int WAVEFORM_BIT  = 0;
  localparam int SOURCE_MSB    = 4;
  localparam int SOURCE_LSB    = 1;

  localparam logic [7:0] LADDER_POWER_RESET = 8'h00;
  localparam logic [2:0] CONTRAST_RESET     = 3'h0;
  localparam logic [3:0] SOURCE_RESET       = 4'h0;
  localparam logic       TYPE_RESET         = 1'h0;
  localparam logic [2:0] LENGTH_RESET       = 3'h0;
  localparam logic [4:0] COUNT_RESET        = 5'h00;
  localparam logic [7:0] RDATA_RESET        = 8'h00;

  localparam logic [4:0] TYPE_A_LAST = 5'h0F;
  localparam logic [4:0] TYPE_B_LAST = 5'h1F;

  localparam logic [2:0] CONTRAST_BYPASS = 3'h0;

  localparam logic [3:0] SRC_LADDER_EXT_VLCD3 = 4'h1;
  localparam logic [3:0] SRC_LADDER_FVR       = 4'h3;

  localparam logic [1:0] PWR_OFF    = 2'h0;
  localparam logic [1:0] PWR_LOW    = 2'h1;
  localparam logic [1:0] PWR_MEDIUM = 2'h2;
  localparam logic [1:0] PWR_HIGH   = 2'h3;

  typedef enum logic [0:0] {
    PHASE_A = 1'b0,
    PHASE_B = 1'b1
  } phase_type;

endpackage : ladder_pkg

/* File: ladder_power_timing.sv */
// Ladder A/B power phase timing, buffer gating and contrast tap select
`timescale 1ns/1ps
`default_nettype none

module ladder_power_timing
  import ladder_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       lcd_tick_i,
  input  wire logic [1:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic      [1:0] ladder_power_o,
  output logic            ladder_connected_o,
  output logic            buffer_enable_o,
  output logic            contrast_bypass_o,
  output logic      [2:0] contrast_tap_o,
  output logic            phase_b_o
);

  typedef struct packed {
    logic [7:0] ladder_power_control;
    logic [2:0] contrast_tap_select;
    logic       waveform_type_select;
    logic [3:0] voltage_source;
    logic [2:0] active_length;
    logic       active_type;
    logic [4:0] count;
    phase_type  phase;
    logic [7:0] rdata;
    logic [1:0] power;
    logic       connected;
    logic       buffer_on;
    logic       bypass;
    logic [2:0] tap;
  } state_type;

  state_type cur;
  state_type nxt;

  logic       internal_only;
  logic [4:0] last_count;
  logic       boundary;
  phase_type  next_phase;
  logic [1:0] next_power;

  // Contrast network only meaningful for voltage sources SRC_LADDER_EXT_VLCD3 through SRC_LADDER_FVR (1..3)
  assign internal_only = (cur.voltage_source >= SRC_LADDER_EXT_VLCD3) &&
                         (cur.voltage_source <= SRC_LADDER_FVR);

  always_comb begin
    nxt = cur;

    if (wr_i) begin
      if (addr_i == ADDR_LADDER_POWER) begin
        nxt.ladder_power_control = wdata_i;
      end else if (addr_i == ADDR_CONTRAST) begin
        nxt.contrast_tap_select = wdata_i[CONTRAST_MSB:CONTRAST_LSB];
      end else if (addr_i == ADDR_WAVEFORM) begin
        nxt.waveform_type_select = wdata_i[WAVEFORM_BIT];
        nxt.voltage_source = wdata_i[SOURCE_MSB:SOURCE_LSB];
      end
    end

    nxt.rdata = 8'h00;
    if (rd_i) begin
      if (addr_i == ADDR_LADDER_POWER) begin
        nxt.rdata = cur.ladder_power_control;
      end else if (addr_i == ADDR_CONTRAST) begin
        nxt.rdata = {5'h00, cur.contrast_tap_select};
      end else if (addr_i == ADDR_WAVEFORM) begin
        nxt.rdata = {3'h0, cur.voltage_source, cur.waveform_type_select};
      end else begin
        nxt.rdata = {cur.count, cur.active_type, cur.phase == PHASE_B,
                     cur.buffer_on};
      end
    end

    // Interval length from the latched waveform type
    last_count = cur.active_type ? TYPE_B_LAST : TYPE_A_LAST;
    boundary   = lcd_tick_i && (cur.count == last_count);

    if (lcd_tick_i) begin
      if (boundary) begin
        nxt.count = 5'h00;
        // New A-time length and waveform type only take hold at an interval start
        nxt.active_length =
          cur.ladder_power_control[A_LENGTH_MSB:A_LENGTH_LSB];
        nxt.active_type = cur.waveform_type_select;
      end else begin
        nxt.count = cur.count + 5'h01;
      end
    end

    // A-time covers counts 0..n-1; n of zero never enters A-time
    if (nxt.count < {2'h0, nxt.active_length}) begin
      next_phase = PHASE_A;
    end else begin
      next_phase = PHASE_B;
    end
    nxt.phase = next_phase;

    if (next_phase == PHASE_A) begin
      next_power =
        cur.ladder_power_control[A_POWER_MSB:A_POWER_LSB];
    end else begin
      next_power =
        cur.ladder_power_control[B_POWER_MSB:B_POWER_LSB];
    end
    nxt.power     = next_power;
    nxt.connected = (next_power != PWR_OFF);

    if (cur.ladder_power_control[IDLE_BIT]) begin
      nxt.buffer_on = (next_phase == PHASE_A);
    end else begin
      nxt.buffer_on = 1'b1;
    end

    if (internal_only) begin
      nxt.bypass = (cur.contrast_tap_select == CONTRAST_BYPASS);
      nxt.tap    = cur.contrast_tap_select;
    end else begin
      nxt.bypass = 1'b1;
      nxt.tap    = CONTRAST_BYPASS;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cur.ladder_power_control <= LADDER_POWER_RESET;
      cur.contrast_tap_select  <= CONTRAST_RESET;
      cur.waveform_type_select <= TYPE_RESET;
      cur.voltage_source       <= SOURCE_RESET;
      cur.active_length        <= LENGTH_RESET;
      cur.active_type          <= TYPE_RESET;
      cur.count                <= COUNT_RESET;
      cur.phase                <= PHASE_B;
      cur.rdata                <= RDATA_RESET;
      cur.power                <= PWR_OFF;
      cur.connected            <= 1'b0;
      cur.buffer_on            <= 1'b1;
      cur.bypass               <= 1'b1;
      cur.tap                  <= CONTRAST_BYPASS;
    end else begin
      cur <= nxt;
    end
  end

  assign rdata_o            = cur.rdata;
  assign ladder_power_o     = cur.power;
  assign ladder_connected_o = cur.connected;
  assign buffer_enable_o    = cur.buffer_on;
  assign contrast_bypass_o  = cur.bypass;
  assign contrast_tap_o     = cur.tap;
  assign phase_b_o          = (cur.phase == PHASE_B);

endmodule : ladder_power_timing

`default_nettype wire

/* File: ladder_ref_model.sv */
// LCD clock tick source with a settable spacing
`timescale 1ns/1ps
`default_nettype none
module ladder_ref_model (
  input  wire logic       clock_i,
  input  wire logic [1:0] gap_i,
  output logic            tick_o
);
  logic [1:0] cnt = 2'h0;
  assign tick_o = cnt == gap_i;
  always @(posedge clock_i) cnt <= tick_o ? 2'h0 : cnt + 2'h1;
endmodule : ladder_ref_model
`default_nettype wire

/* File: ladder_power_timing_checker.sv */
// Port assertions for the ladder timing block
`timescale 1ns/1ps
`default_nettype none
module ladder_power_timing_checker (
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       lcd_tick_i,
  input wire logic       wr_i,
  input wire logic [1:0] ladder_power_o,
  input wire logic       ladder_connected_o,
  input wire logic       buffer_enable_o,
  input wire logic       contrast_bypass_o,
  input wire logic [2:0] contrast_tap_o,
  input wire logic       phase_b_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [3:0] a_ticks;
  always_ff @(posedge clock_i)
    a_ticks <= (!nrst_i || phase_b_o) ? 4'h0 : a_ticks + 4'(lcd_tick_i);
  a_buf_in_a: assert property (!phase_b_o |-> buffer_enable_o)
    else $error("buffer off in A-time");
  a_a_bound: assert property (a_ticks <= 4'h7)
    else $error("A-time too long");
  a_phase_tick: assert property ($changed(phase_b_o) |->
    $past(lcd_tick_i)) else $error("phase moved without tick");
  a_conn_pwr: assert property (
    ladder_connected_o == |ladder_power_o) else $error("connect wrong");
  a_tap_bypass: assert property (
    contrast_bypass_o == (contrast_tap_o == 3'h0)) else $error("tap wrong");
  a_pwr_cause: assert property ($changed(ladder_power_o) |->
    $past(lcd_tick_i || wr_i) || $past(wr_i, 2)) else $error("power step");
  a_buf_cause: assert property ($changed(buffer_enable_o) |->
    $past(lcd_tick_i || wr_i) || $past(wr_i, 2)) else $error("buffer step");
  a_tap_cause: assert property ($changed(contrast_tap_o) |->
    $past(wr_i) || $past(wr_i, 2)) else $error("tap step");
  c_rise: cover property ($rose(phase_b_o));
  c_fall: cover property ($fell(phase_b_o));
  c_idle: cover property (phase_b_o && !buffer_enable_o);
endmodule : ladder_power_timing_checker
bind ladder_power_timing ladder_power_timing_checker watch (.*);
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the ladder timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top import ladder_pkg::*;;
  logic       clock_i = 1'h0, nrst_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0, ok;
  logic [1:0] addr_i = 2'h0, gap = 2'h0, ladder_power_o;
  logic [2:0] contrast_tap_o;
  logic [7:0] wdata_i = 8'h00, rdata_o, v, exp_q[$];
  logic       lcd_tick_i, ladder_connected_o, buffer_enable_o, rd_d = 1'h0;
  logic       contrast_bypass_o, phase_b_o;
  int         mismatches = 0, total_checks = 0, n_a;
  always #5 clock_i = ~clock_i;
  ladder_ref_model model (.clock_i, .gap_i(gap), .tick_o(lcd_tick_i));
  ladder_power_timing dut (.*);
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) mismatches++;
    if (g !== e) $display("[ERR] %0t exp %h got %h", $time, e, g);
  endtask : chk
  task automatic bus(input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    if (r) exp_q.push_back(d);
    {wr_i, rd_i, addr_i, wdata_i} <= {!r, r, a, d};
    @(posedge clock_i);
    {wr_i, rd_i} <= 2'h0;
  endtask : bus
  always @(posedge clock_i) begin
    if (rd_d) chk(exp_q.pop_front(), rdata_o);
    else if (rdata_o !== 8'h00) chk(8'h00, rdata_o);
    rd_d <= rd_i;
  end
  task automatic run(input logic [7:0] lp, input logic t, input logic [1:0] g);
    gap <= g;
    bus(0, ADDR_LADDER_POWER, lp);
    bus(0, ADDR_WAVEFORM, {7'h01, t});
    bus(1, ADDR_LADDER_POWER, lp);
    repeat (200) @(negedge clock_i);
    n_a = 0;
    ok = 1'h1;
    repeat (64 * (g + 1)) @(negedge clock_i) begin
      n_a += !phase_b_o;
      ok &= buffer_enable_o === (!phase_b_o || !lp[3]) &&
        ladder_power_o === (phase_b_o ? lp[5:4] : lp[7:6]) &&
        ladder_connected_o === ((phase_b_o ? lp[5:4] : lp[7:6]) != 2'h0);
    end
    chk(8'((g + 1) * lp[2:0] * 64 / (t ? 32 : 16)), 8'(n_a));
    chk(8'h01, {7'h00, ok});
  endtask : run
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    void'($urandom(32'hF0100D4E));
    repeat (3) @(posedge clock_i);
    nrst_i <= 1'h1;
    bus(1, ADDR_CONTRAST, 8'h00);
    bus(0, ADDR_WAVEFORM, 8'h02);
    for (int i = 0; i < 8; i++) begin
      v = {5'($urandom), 3'(i)};
      bus(0, ADDR_CONTRAST, v);
      bus(1, ADDR_CONTRAST, {5'h00, v[2:0]});
      repeat (2) @(negedge clock_i);
      chk(8'({!i,v[2:0]}), 8'({contrast_bypass_o, contrast_tap_o}));
    end
    bus(0, ADDR_WAVEFORM, 8'h10);
    repeat (2) @(negedge clock_i);
    chk(8'h08, 8'({contrast_bypass_o, contrast_tap_o}));
    for (int k = 0; k < 6; k++)
      run({5'($urandom), k < 2 ? 3'h7 : k < 4 ? 3'h0 : 3'($urandom)},
        k[0], 2'($urandom));
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
